// >>> iplr_cfg.svh
/*
 * Offsets, field masks, reset values and priority encodings of the level
 * register bank. Assumes a 32-bit APB slave with one word per register.
 */
`ifndef IPLR_CFG_SVH
`define IPLR_CFG_SVH

// register indices of the level registers; the byte address is index x 4
`define IPLR_IDX_G21 20'h0F029
`define IPLR_IDX_G30 20'h0F02A
`define IPLR_IDX_G31 20'h0F02B
`define IPLR_IDX_G40 20'h0F02C
`define IPLR_IDX_G51 20'h0F02D
`define IPLR_IDX_G60 20'h0F02E
`define IPLR_IDX_STATUS 20'h0F02F

// implemented bits of each register
`define IPLR_MASK_G21 8'hC0
`define IPLR_MASK_G30 8'hFF
`define IPLR_MASK_G31 8'h30
`define IPLR_MASK_G40 8'h0F
`define IPLR_MASK_G51 8'h0F
`define IPLR_MASK_G60 8'hFF

`define IPLR_RESET 8'h00
`define IPLR_LEVEL_1 2'h0
`define IPLR_LEVEL_4 2'h3

`endif

// >>> iplr_pkg.sv
/*
 * Types shared by the level register bank.
 * Assumes iplr_cfg.svh supplies the numeric constants.
 */
`default_nettype none

package iplr_pkg;
    typedef struct packed {
        logic [19:0] paddr;
        logic pwrite;
        logic [31:0] pwdata;
    } iplr_apb_req_type;

    typedef enum logic [1:0] {
        IPLR_IDLE = 2'b00,
        IPLR_ACCESS = 2'b01
    } iplr_state_type;
endpackage : iplr_pkg

`default_nettype wire

// >>> iplr_top.sv
/*
 * Bank of six 8-bit priority level registers behind an APB slave, with a
 * per-source level output and an arbiter over the mapped sources.
 * Assumes a single 100 MHz clock, synchronous inputs, and a level control
 * enable and in-service level mask from the neighbouring controller.
 */
// Design decision made here: register access over APB.
// Operation
// - write access allowed only while level control enabled
// - writes ignored while control disabled
// - disabled read returns held contents
// - 2-bit field codes levels 1 to 4
// - registers 8 bits, reset to zero
// - group 2-1: field 7:6 only
// - group 3-0: four fields
// - group 3-1: field 5:4 only
// - group 4-0: fields 3:2, 1:0
// - group 5-1: fields 3:2, 1:0
// - group 6-0: four fields
// - highest level wins, then lowest source
// - refuse requests below in-service level
`timescale 1ns/1ps
`default_nettype none
`include "iplr_cfg.svh"

module iplr_top
    import iplr_pkg::*;
#(
    parameter int NSRC = 16
) (
    // clock and reset
    input wire logic clk,
    input wire logic resetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [19:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // neighbouring controller
    input wire logic level_control_enable,
    input wire logic [3:0] in_service_level,
    input wire logic [NSRC-1:0] irq_req,
    // level and arbitration results
    output logic [2*NSRC-1:0] src_level,
    output logic grant_valid,
    output logic [4:0] grant_src
);

    localparam int NREG = 6;
    localparam logic [7:0] MASKS [NREG] = '{`IPLR_MASK_G21, `IPLR_MASK_G30, `IPLR_MASK_G31,
                                           `IPLR_MASK_G40, `IPLR_MASK_G51, `IPLR_MASK_G60};
    localparam logic [19:0] ADDRS [NREG] = '{`IPLR_IDX_G21, `IPLR_IDX_G30, `IPLR_IDX_G31,
                                            `IPLR_IDX_G40, `IPLR_IDX_G51, `IPLR_IDX_G60};
    localparam logic [19:0] STATUS_IDX = `IPLR_IDX_STATUS;

    iplr_apb_req_type req;
    iplr_state_type state_q;
    iplr_state_type state_d;
    logic [7:0] lvl_q [NREG];
    logic [NREG-1:0] hit;
    logic [NREG-1:0] wr_en;
    logic [7:0] rd_mux;
    logic status_hit;
    logic mapped;
    logic [31:0] prdata_d;
    logic [2*NSRC-1:0] levels;
    logic [1:0] floor_lvl;
    logic any_service;
    logic [NSRC-1:0] eligible;
    logic win_valid;
    logic [4:0] win_src;

    assign req = '{paddr: paddr, pwrite: pwrite, pwdata: pwdata};

    // register index decode
    function automatic logic [NREG-1:0] decode(input logic [19:0] a);
        logic [NREG-1:0] h;
        h = '0;
        for (int i = 0; i < NREG; i++) begin
            h[i] = (a == {ADDRS[i][17:0], 2'b00});
        end
        return h;
    endfunction : decode

    assign hit = decode(req.paddr);
    assign status_hit = (req.paddr == {STATUS_IDX[17:0], 2'b00});
    assign mapped = (|hit) | status_hit;
    wire access_cyc = psel & penable & (state_q == IPLR_ACCESS);

    always_comb begin
        state_d = state_q;
        unique case (state_q)
            IPLR_IDLE: if (psel && !penable) state_d = IPLR_ACCESS;
            IPLR_ACCESS: state_d = IPLR_IDLE;
            default: state_d = IPLR_IDLE;
        endcase
    end

    // level registers
    genvar g;
    generate
        for (g = 0; g < NREG; g++) begin : g_reg
            assign wr_en[g] = access_cyc & req.pwrite & hit[g] & level_control_enable;
            always_ff @(posedge clk or negedge resetn) begin
                if (!resetn) begin
                    lvl_q[g] <= `IPLR_RESET;
                end else if (wr_en[g]) begin
                    lvl_q[g] <= req.pwdata[7:0] & MASKS[g];
                end
            end
        end
    endgenerate

    // registers hold their last enabled contents, so disabled reads see them
    always_comb begin
        rd_mux = 8'h00;
        for (int i = 0; i < NREG; i++) begin
            if (hit[i]) rd_mux = lvl_q[i];
        end
    end
    assign prdata_d = status_hit ? {30'h0, req.pwrite, level_control_enable} : {24'h0, rd_mux};

    // per-source level map in source-number order
    assign levels = {
        lvl_q[5][7:6], lvl_q[5][5:4], lvl_q[5][3:2], lvl_q[5][1:0],
        lvl_q[4][3:2], lvl_q[4][1:0], lvl_q[3][3:2], lvl_q[3][1:0],
        lvl_q[2][5:4], lvl_q[1][7:6], lvl_q[1][5:4], lvl_q[1][3:2],
        lvl_q[1][1:0], lvl_q[0][7:6], 4'h0
    };

    // floor from the highest in-service level
    assign any_service = |in_service_level;
    assign floor_lvl = in_service_level[3] ? `IPLR_LEVEL_4 :
                       in_service_level[2] ? 2'h2 :
                       in_service_level[1] ? 2'h1 : `IPLR_LEVEL_1;

    generate
        for (g = 0; g < NSRC; g++) begin : g_elig
            assign eligible[g] = irq_req[g] &
                (!any_service || levels[2*g +: 2] >= floor_lvl);
        end
    endgenerate

    always_comb begin
        logic [1:0] best;
        best = `IPLR_LEVEL_1;
        win_valid = 1'b0;
        win_src = 5'h00;
        for (int i = 0; i < NSRC; i++) begin
            if (eligible[i] && level_control_enable &&
                (!win_valid || levels[2*i +: 2] > best)) begin
                win_valid = 1'b1;
                win_src = 5'(i);
                best = levels[2*i +: 2];
            end
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state_q <= IPLR_IDLE;
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
            src_level <= '0;
            grant_valid <= 1'b0;
            grant_src <= 5'h00;
        end else begin
            state_q <= state_d;
            pready <= (state_d == IPLR_ACCESS);
            pslverr <= (state_d == IPLR_ACCESS) & ~(mapped);
            prdata <= (state_d == IPLR_ACCESS && !req.pwrite) ? prdata_d : 32'h0000_0000;
            src_level <= levels;
            grant_valid <= win_valid;
            grant_src <= win_src;
        end
    end

endmodule : iplr_top

`default_nettype wire

// >>> iplr_top_properties.sv
/* checker for iplr_top port timing and read masks.
   assumes one clock domain and the byte addresses of iplr_cfg.svh. */
`timescale 1ns/1ps
`default_nettype none
`include "iplr_cfg.svh"
module iplr_props #(
    parameter int NSRC = 16
) (
    // clock and reset
    input wire logic clk,
    input wire logic resetn,
    // apb
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [19:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // controller side
    input wire logic level_control_enable,
    input wire logic [NSRC-1:0] irq_req,
    input wire logic [2*NSRC-1:0] src_level,
    input wire logic grant_valid,
    input wire logic [4:0] grant_src
);
    localparam logic [19:0] A21 = {18'(`IPLR_IDX_G21), 2'b00};
    localparam logic [19:0] A30 = {18'(`IPLR_IDX_G30), 2'b00};
    localparam logic [19:0] A31 = {18'(`IPLR_IDX_G31), 2'b00};
    localparam logic [19:0] A40 = {18'(`IPLR_IDX_G40), 2'b00};
    localparam logic [19:0] A51 = {18'(`IPLR_IDX_G51), 2'b00};
    localparam logic [19:0] A60 = {18'(`IPLR_IDX_G60), 2'b00};
    logic [7:0] rmask;
    assign rmask = paddr == A21 ? `IPLR_MASK_G21 : paddr == A30 ? `IPLR_MASK_G30 :
        paddr == A31 ? `IPLR_MASK_G31 : paddr == A40 ? `IPLR_MASK_G40 :
        paddr == A51 ? `IPLR_MASK_G51 : paddr == A60 ? `IPLR_MASK_G60 : 8'h01;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    property p_rdy; psel && !penable |=> pready; endproperty
    a_rdy: assert property (p_rdy) else $error("no ready after setup");
    property p_one; pready |=> !pready; endproperty
    a_one: assert property (p_one) else $error("ready held too long");
    property p_err; pslverr |-> pready; endproperty
    a_err: assert property (p_err) else $error("error without ready");
    property p_zero; !pready |-> prdata == 32'h0; endproperty
    a_zero: assert property (p_zero) else $error("read data outside access");
    property p_mask; pready && !pwrite && !pslverr |-> (prdata & ~{24'h0, rmask}) == 32'h0; endproperty
    a_mask: assert property (p_mask) else $error("unimplemented bit set");
    property p_hold; !level_control_enable [*3] |-> $stable(src_level); endproperty
    a_hold: assert property (p_hold) else $error("level changed while disabled");
    property p_grant; grant_valid |-> ($past(irq_req) >> grant_src) & 1; endproperty
    a_grant: assert property (p_grant) else $error("grant to idle source");
    property p_rst; $rose(resetn) |-> src_level == '0 && !grant_valid && !pready; endproperty
    a_rst: assert property (p_rst) else $error("outputs not clear after reset");
endmodule : iplr_props
bind iplr_top iplr_props #(.NSRC(NSRC)) i_props (.*);
`default_nettype wire

// >>> testbench.sv
/* self-checking bench for iplr_top with a byte model of the six registers.
   assumes iplr_props is bound to the design. */
`timescale 1ns/1ps
`default_nettype none
`include "iplr_cfg.svh"
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin fail_count++; $display("CHECK FAILED %0t got %h exp %h", $time, a, e); end end
module testbench;
    logic clk = 0, resetn = 0, psel = 0, penable = 0, pwrite = 0, level_control_enable = 0, er;
    logic [19:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, rd, w, src_level;
    logic [3:0] in_service_level = '0;
    logic [15:0] irq_req = '0;
    logic pready, pslverr, grant_valid;
    logic [4:0] grant_src;
    logic [19:0] ad [6] = '{`IPLR_IDX_G21 << 2, `IPLR_IDX_G30 << 2, `IPLR_IDX_G31 << 2, `IPLR_IDX_G40 << 2,
        `IPLR_IDX_G51 << 2, `IPLR_IDX_G60 << 2};
    logic [7:0] mk [6] = '{`IPLR_MASK_G21, `IPLR_MASK_G30, `IPLR_MASK_G31, `IPLR_MASK_G40, `IPLR_MASK_G51, `IPLR_MASK_G60};
    logic [7:0] m [6] = '{default: 8'h00};
    int fail_count = 0, n_tests = 0, i2;
    logic [31:0] lv_exp;
    // per-source level codes in source-number order, sources 0 and 1 fixed at level 1
    assign lv_exp = {m[5][7:6], m[5][5:4], m[5][3:2], m[5][1:0], m[4][3:2], m[4][1:0],
        m[3][3:2], m[3][1:0], m[2][5:4], m[1], m[0][7:6], 4'h0};
    // highest eligible level wins, ties to the lowest source
    function automatic logic [5:0] model_grant(input logic [31:0] lv, input logic [15:0] rq, input logic [3:0] sv);
        int fl;
        int best;
        int win;
        fl = sv[3] ? 3 : sv[2] ? 2 : sv[1] ? 1 : 0;
        best = -1;
        win = 0;
        for (int i = 0; i < 16; i++) begin
            if (rq[i] && int'(lv[2*i +: 2]) >= fl && int'(lv[2*i +: 2]) > best) begin
                best = int'(lv[2*i +: 2]);
                win = i;
            end
        end
        return {best >= 0, 5'(win)};
    endfunction : model_grant
    always #5 clk = ~clk;
    iplr_top i_dut (.*);
    task final_report;
        $display("tests %0d failures %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : final_report
    task apb(input logic [19:0] a, input logic wr, input logic [31:0] d);
        int n;
        @(posedge clk);
        psel <= 1;
        penable <= 0;
        paddr <= a;
        pwrite <= wr;
        pwdata <= d;
        irq_req <= 16'($urandom);
        in_service_level <= 4'($urandom);
        @(posedge clk);
        penable <= 1;
        n = 0;
        do begin @(posedge clk); n++; end while (pready !== 1'b1 && n < 20);
        `CHK(pready, 1'b1)
        rd = prdata;
        er = pslverr;
        psel <= 0;
        penable <= 0;
    endtask : apb
    initial begin
        void'($urandom(32'he7c9));
        repeat (5) @(posedge clk);
        resetn <= 1;
        // off, on, off, on: the first pass sees reset values only
        for (int k = 0; k < 4; k++) begin
            level_control_enable <= k[0];
            for (int i = 0; i < 6; i++) begin
                w = k == 3 ? 32'hFFFF_FFFF : $urandom;
                apb(ad[i], 1, w);
                if (k[0]) m[i] = w[7:0] & mk[i];
                apb(ad[i], 0, 32'h0);
                `CHK(rd, {24'h0, m[i]})
                `CHK(er, 1'b0)
            end
        end
        `CHK(src_level[5:4], m[0][7:6])
        for (int t = 0; t < 40; t++) begin
            i2 = $urandom_range(5);
            w = $urandom;
            apb(ad[i2], 1, w);
            m[i2] = w[7:0] & mk[i2];
            @(posedge clk);
            irq_req <= 16'($urandom);
            in_service_level <= 4'($urandom);
            @(posedge clk);
            @(posedge clk);
            `CHK(src_level, lv_exp)
            `CHK({grant_valid, grant_src}, model_grant(lv_exp, irq_req, in_service_level))
        end
        apb(20'h0F030, 0, 32'h0);
        `CHK(er, 1'b1)
        final_report();
    end
    initial begin
        #20000;
        fail_count++;
        final_report();
    end
endmodule : testbench
`default_nettype wire
